// ==== rtl/ssp_regs.svh ====
// constants of the servo stop and power cut controller
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define SSP_CLOCK_PERIOD_NS 8
`define SSP_MS_NS           1000000
`define SSP_STOP_BRAKE_HOLD  2'h0
`define SSP_STOP_BRAKE_COAST 2'h1
`define SSP_STOP_COAST      2'h2
`define SSP_STOP_MODE_RST   2'h0
`define SSP_G2_SEL_RST      1'h0
`define SSP_HOLD_MIN        10'h014
`define SSP_HOLD_MAX        10'h3E8
`define SSP_MAXSPD_MIN      7'h01
`define SSP_MAXSPD_MAX      7'h64
`define SSP_MAXSPD_RST      7'h32
`define SSP_SPEED_UNIT      16'h0064
`define SSP_MAXSPD_SPAN     7'h65
`define SSP_RES_STEP        16'h0010
`endif

// ==== rtl/ssp_pkg.sv ====
// types of the servo stop and power cut controller
`default_nettype none
package ssp_pkg;
  typedef enum logic [4:0] {
    SSP_RUN   = 5'h01,
    SSP_ZERO  = 5'h02,
    SSP_BRAKE = 5'h04,
    SSP_COAST = 5'h08,
    SSP_HOLD  = 5'h10
  } ssp_state_type;
  typedef enum logic [1:0] {
    SSP_MODE_POSITION = 2'h0,
    SSP_MODE_SPEED    = 2'h1,
    SSP_MODE_FORCE    = 2'h2
  } ssp_ctrl_mode_type;
endpackage : ssp_pkg
`default_nettype wire

// ==== rtl/ssp_ms_timer.sv ====
// millisecond counter timing a main circuit interruption
`default_nettype none
module ssp_ms_timer #(
  parameter int CYCLES_PER_MS = 125000,
  parameter int COUNT_W       = 11
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               nrst,
  // control
  input  wire logic               run,
  // result
  output logic [COUNT_W-1:0]      msCount
);
  localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);
  logic [PRE_W-1:0] prescale;
  wire              msTick = (prescale == PRE_W'(CYCLES_PER_MS - 1));
  wire              atTop  = &msCount;

  if (CYCLES_PER_MS < 1 || COUNT_W < 11) begin : g_check
    $error("ssp_ms_timer: bad parameters");
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale <= '0;
      msCount  <= '0;
    end else if (!run) begin
      prescale <= '0;
      msCount  <= '0;
    end else begin
      prescale <= msTick ? '0 : prescale + PRE_W'(1);
      if (msTick && !atTop) msCount <= msCount + COUNT_W'(1);
    end
  end
endmodule : ssp_ms_timer
`default_nettype wire

// ==== rtl/ssp_stop_control.sv ====
// stop sequencing, power cut timing and speed limit of a linear servo drive
`include "ssp_regs.svh"
`default_nettype none
module ssp_stop_control #(
  parameter int CYCLES_PER_MS = `SSP_MS_NS / `SSP_CLOCK_PERIOD_NS,
  parameter int STOP_SPEED    = 10
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // host commands and settings
  input  wire logic                       servoOn,
  input  wire logic                       restart,
  input  wire ssp_pkg::ssp_ctrl_mode_type controlMode,
  input  wire logic [1:0]                 stopModeSelect,
  input  wire logic                       group2StopSelect,
  input  wire logic [9:0]                 powerCutHoldTime,
  input  wire logic [6:0]                 maxSpeedSetting,
  input  wire logic signed [15:0]         speedReferenceIn,
  // drive status
  input  wire logic                       groupOneAlarm,
  input  wire logic                       groupTwoAlarm,
  input  wire logic                       undervoltageAlarm,
  input  wire logic                       mainPowerOk,
  input  wire logic                       controlPowerOk,
  input  wire logic                       coastVariant,
  input  wire logic signed [15:0]         speedFeedback,
  // stop outputs
  output var ssp_pkg::ssp_state_type      stopState,
  output logic                            motorPower,
  output logic                            dynamicBrake,
  output logic signed [15:0]              speedReference,
  output logic                            servoReady,
  output logic                            powerCut,
  output logic                            overspeedAlarm,
  output logic [15:0]                     encoderResolutionMax
);
  import ssp_pkg::*;

  if (CYCLES_PER_MS < 1 || STOP_SPEED < 0 || STOP_SPEED > 32767) begin : g_check
    $error("ssp_stop_control: bad parameters");
  end

  // settings applied at restart, the hold flag taken at stop entry and the cut timer count
  logic [1:0] stopModeLatched;
  logic       group2SelLatched;
  logic [6:0] maxSpeedLatched;
  logic       afterHold;
  logic [10:0] msCount;

  ssp_ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS),
    .COUNT_W       (11)
  ) u_timer (
    .clock   (clock),
    .nrst    (nrst),
    .run     (!mainPowerOk && controlPowerOk),
    .msCount (msCount)
  );

  // decode
  wire [9:0]  holdClamped = (powerCutHoldTime < `SSP_HOLD_MIN) ? `SSP_HOLD_MIN :
                            (powerCutHoldTime > `SSP_HOLD_MAX) ? `SSP_HOLD_MAX : powerCutHoldTime;
  wire        cutNow      = !mainPowerOk && (msCount > {1'b0, holdClamped});
  wire        ctrlLoss    = !controlPowerOk;
  wire        g2Zero      = groupTwoAlarm && !group2SelLatched && (controlMode != SSP_MODE_FORCE);
  wire        anyAlarm    = groupOneAlarm || groupTwoAlarm || undervoltageAlarm;
  wire        stopReq     = ctrlLoss || cutNow || anyAlarm || !servoOn;
  wire        setOk       = (stopModeSelect <= `SSP_STOP_COAST);
  wire        spdOk       = (maxSpeedSetting >= `SSP_MAXSPD_MIN) && (maxSpeedSetting <= `SSP_MAXSPD_MAX);
  wire [15:0] speedMag    = speedFeedback[15] ? 16'(-speedFeedback) : 16'(speedFeedback);
  wire        stopped     = speedMag <= 16'(STOP_SPEED);
  wire [15:0] speedLimit  = 16'(maxSpeedLatched * `SSP_SPEED_UNIT);
  wire        modeHold    = (stopModeLatched == `SSP_STOP_BRAKE_HOLD);
  wire        modeCoast   = (stopModeLatched == `SSP_STOP_COAST);

  // stop entry chosen by priority: control loss, power cut unless undervoltage alarm, alarms, servo-off
  ssp_state_type entryState;
  logic          entryHold;
  always_comb begin
    entryHold = modeHold;
    if (ctrlLoss) begin
      entryState = coastVariant ? SSP_COAST : SSP_BRAKE;
      entryHold  = 1'b1;
    end else if (cutNow && !undervoltageAlarm) begin
      entryState = SSP_BRAKE;
      entryHold  = 1'b1;
    end else if (g2Zero && !groupOneAlarm && !undervoltageAlarm) begin
      entryState = SSP_ZERO;
    end else begin
      entryState = modeCoast ? SSP_COAST : SSP_BRAKE;
    end
  end

  ssp_state_type next_stopState;
  always_comb begin
    next_stopState = stopState;
    unique case (stopState)
      SSP_RUN:   if (stopReq) next_stopState = entryState;
      SSP_ZERO:  if (!stopReq) next_stopState = SSP_RUN;
                 else if (stopped) next_stopState = afterHold ? SSP_HOLD : SSP_COAST;
      SSP_BRAKE: if (!stopReq) next_stopState = SSP_RUN;
                 else if (stopped) next_stopState = afterHold ? SSP_HOLD : SSP_COAST;
      SSP_COAST: if (!stopReq) next_stopState = SSP_RUN;
      SSP_HOLD:  if (!stopReq) next_stopState = SSP_RUN;
      default:   next_stopState = SSP_RUN;
    endcase
  end

  wire next_motorPower = (next_stopState == SSP_RUN) || (next_stopState == SSP_ZERO);
  wire next_brake      = (next_stopState == SSP_BRAKE) || (next_stopState == SSP_HOLD);
  wire signed [15:0] next_speedRef = (next_stopState == SSP_RUN) ? speedReferenceIn : 16'sh0000;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stopModeLatched  <= `SSP_STOP_MODE_RST;
      group2SelLatched <= `SSP_G2_SEL_RST;
      maxSpeedLatched  <= `SSP_MAXSPD_RST;
    end else if (restart) begin
      if (setOk) stopModeLatched <= stopModeSelect;
      group2SelLatched <= group2StopSelect;
      if (spdOk) maxSpeedLatched <= maxSpeedSetting;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stopState      <= SSP_HOLD;
      afterHold      <= 1'b1;
      motorPower     <= 1'b0;
      dynamicBrake   <= 1'b1;
      speedReference <= 16'sh0000;
    end else begin
      stopState      <= next_stopState;
      if (stopState == SSP_RUN && stopReq) afterHold <= entryHold;
      motorPower     <= next_motorPower;
      dynamicBrake   <= next_brake;
      speedReference <= next_speedRef;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      servoReady           <= 1'b0;
      powerCut             <= 1'b0;
      overspeedAlarm       <= 1'b0;
      encoderResolutionMax <= 16'h0000;
    end else begin
      servoReady           <= !cutNow && !ctrlLoss && !anyAlarm && mainPowerOk;
      powerCut             <= cutNow;
      overspeedAlarm       <= speedMag > speedLimit;
      encoderResolutionMax <= 16'(`SSP_RES_STEP * (`SSP_MAXSPD_SPAN - maxSpeedLatched));
    end
  end

  // checks
  property p_coast_off;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_RUN && !servoOn && !anyAlarm && !cutNow && !ctrlLoss && modeCoast)
      |=> (stopState == SSP_COAST) && !dynamicBrake && !motorPower;
  endproperty
  a_coast_off: assert property (p_coast_off) else $error("servo-off coast not taken");

  property p_g1_brake;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_RUN && groupOneAlarm && !cutNow && !ctrlLoss && !modeCoast)
      |=> (stopState == SSP_BRAKE) && dynamicBrake;
  endproperty
  a_g1_brake: assert property (p_g1_brake) else $error("group one alarm did not brake");

  property p_g2_zero;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_RUN && groupTwoAlarm && !groupOneAlarm && !undervoltageAlarm && !cutNow
       && !ctrlLoss && !group2SelLatched && controlMode != SSP_MODE_FORCE)
      |=> (stopState == SSP_ZERO) && motorPower;
  endproperty
  a_g2_zero: assert property (p_g2_zero) else $error("group two zero-speed stop missing");

  property p_zero_ref;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_ZERO) |-> (speedReference == 16'sh0000);
  endproperty
  a_zero_ref: assert property (p_zero_ref) else $error("speed reference not zero in stop");

  property p_force_ignores;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_RUN && controlMode == SSP_MODE_FORCE && groupTwoAlarm && !ctrlLoss && !cutNow)
      |=> (stopState != SSP_ZERO);
  endproperty
  a_force_ignores: assert property (p_force_ignores) else $error("zero stop in force control");

  property p_cut_brake;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_RUN && cutNow && !undervoltageAlarm && !ctrlLoss)
      |=> (stopState == SSP_BRAKE) ##1 !servoReady;
  endproperty
  a_cut_brake: assert property (p_cut_brake) else $error("power cut did not brake");

  property p_ctrl_loss;
    @(posedge clock) disable iff (!nrst)
      (stopState == SSP_RUN && ctrlLoss)
      |=> (stopState == (coastVariant ? SSP_COAST : SSP_BRAKE));
  endproperty
  a_ctrl_loss: assert property (p_ctrl_loss) else $error("control loss stop wrong");

  property p_ready_drop;
    @(posedge clock) disable iff (!nrst)
      (!mainPowerOk && controlPowerOk && msCount > {1'b0, holdClamped}) |=> !servoReady && powerCut;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready kept after long cut");

  property p_overspeed;
    @(posedge clock) disable iff (!nrst)
      $stable(maxSpeedLatched) && $stable(speedFeedback) |-> (overspeedAlarm == (speedMag > speedLimit));
  endproperty
  a_overspeed: assert property (p_overspeed) else $error("overspeed alarm mismatch");

  property p_restart_only;
    @(posedge clock) disable iff (!nrst)
      !restart |=> $stable(stopModeLatched) && $stable(maxSpeedLatched) && $stable(group2SelLatched);
  endproperty
  a_restart_only: assert property (p_restart_only) else $error("setting changed without restart");
endmodule : ssp_stop_control
`default_nettype wire

// ==== verification/ssp_host_model.sv ====
// host and motor model facing the stop controller
`default_nettype none
module ssp_host_model (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               nrst,
  // from the controller
  input  wire logic               motorPower,
  input  wire logic signed [15:0] speedReference,
  // from the bench
  input  wire logic signed [15:0] target,
  // to the controller
  output logic signed [15:0]      speedReferenceIn,
  output logic signed [15:0]      speedFeedback
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      speedReferenceIn <= 16'sh0000;
      speedFeedback    <= 16'sh0000;
    end else begin
      // motion started and stopped by ramped references
      if (speedReferenceIn < target - 100)
        speedReferenceIn <= speedReferenceIn + 16'sh0064;
      else if (speedReferenceIn > target + 100)
        speedReferenceIn <= speedReferenceIn - 16'sh0064;
      else
        speedReferenceIn <= target;
      // unpowered motor slows by halving
      speedFeedback <= motorPower ? speedReference : speedFeedback >>> 1;
    end
  end
endmodule : ssp_host_model
`default_nettype wire

// ==== verification/ssp_stop_control_tb.sv ====
// self-checking bench of the stop controller
`default_nettype none
module ssp_stop_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssp_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, restart = 1'b0, group2StopSelect = 1'b0, coastVariant = 1'b0;
  logic sOn = 1'b0, cut = 1'b0;
  logic [4:0] cause = 5'h00;
  ssp_ctrl_mode_type controlMode = SSP_MODE_POSITION;
  logic [1:0] stopModeSelect = 2'h0;
  logic [9:0] powerCutHoldTime = 10'h014;
  logic [6:0] maxSpeedSetting = 7'h32;
  logic signed [15:0] target = 16'sh0000;
  logic signed [15:0] speedReferenceIn, speedFeedback, speedReference;
  ssp_state_type stopState;
  logic motorPower, dynamicBrake, servoReady, powerCut, overspeedAlarm;
  logic [15:0] encoderResolutionMax;
  wire logic servoOn = sOn & ~cause[0];
  wire logic groupOneAlarm = cause[1];
  wire logic groupTwoAlarm = cause[2];
  wire logic controlPowerOk = ~cause[3];
  wire logic undervoltageAlarm = cause[4];
  wire logic mainPowerOk = ~cause[4] & ~cut;
  int n_fail = 0, checks = 0, seed = 37, m, h, k, mode = 0, sel = 0, maxSp = 50;
  always #4 clock = ~clock;
  ssp_stop_control #(.CYCLES_PER_MS(4), .STOP_SPEED(10)) dut (.clock, .nrst, .servoOn, .restart,
    .controlMode, .stopModeSelect, .group2StopSelect, .powerCutHoldTime, .maxSpeedSetting,
    .speedReferenceIn, .groupOneAlarm, .groupTwoAlarm, .undervoltageAlarm, .mainPowerOk,
    .controlPowerOk, .coastVariant, .speedFeedback, .stopState, .motorPower, .dynamicBrake,
    .speedReference, .servoReady, .powerCut, .overspeedAlarm, .encoderResolutionMax);
  ssp_host_model host (.clock, .nrst, .motorPower, .speedReference, .target, .speedReferenceIn,
    .speedFeedback);
  task automatic close_out();
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(string what, int exp, logic [15:0] got);
    checks++;
    if (got !== 16'(exp)) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic waitFor(int st, int lim);
    k = 0;
    while (stopState !== 5'(st) && k < lim) begin
      @(negedge clock);
      k++;
    end
    chk("stop state", st, 16'(stopState));
    if (stopState !== 5'(st))
      close_out();
  endtask : waitFor
  task automatic doRestart(int md, int s, int ms);
    @(posedge clock);
    stopModeSelect <= 2'(md);
    group2StopSelect <= 1'(s);
    maxSpeedSetting <= 7'(ms);
    restart <= 1'b1;
    @(posedge clock);
    restart <= 1'b0;
    stopModeSelect <= 2'(md + 1);
    if (md < 3) mode = md;
    sel = s;
    if (ms >= 1 && ms <= 100) maxSp = ms;
  endtask : doRestart
  // model: first stop state from the causes and latched settings
  function automatic int firstStop();
    int brk;
    brk = (mode == 2) ? 8 : 4;
    if (!controlPowerOk) return coastVariant ? 8 : 4;
    if (groupOneAlarm || undervoltageAlarm) return brk;
    if (groupTwoAlarm && (sel == 1 || controlMode == SSP_MODE_FORCE)) return brk;
    if (groupTwoAlarm) return 2;
    return brk;
  endfunction : firstStop
  task automatic stopCase(int c);
    int first, fin;
    @(posedge clock);
    cause <= 5'(1 << c);
    @(posedge clock);
    @(negedge clock);
    first = firstStop();
    fin = (first == 8) ? 8 : ((c == 3 || mode == 0) ? 16 : 8);
    chk("first stop", first, 16'(stopState));
    if (first == 2) chk("zero reference", 0, speedReference);
    waitFor(fin, 80);
    chk("brake output", fin == 16, 16'(dynamicBrake));
    @(posedge clock);
    cause <= 5'h00;
    waitFor(1, 6);
  endtask : stopCase
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    chk("reset state", 16, 16'(stopState));
    @(posedge clock);
    sOn <= 1'b1;
    target <= 16'sh01F4;
    waitFor(1, 6);
    chk("ready", 1, 16'(servoReady));
    for (int md = 0; md < 4; md++)
      for (int s = 0; s < 2; s++) begin
        doRestart(md, s, 50);
        coastVariant <= 1'(s);
        for (int cm = 0; cm < 3; cm++) begin
          @(posedge clock);
          controlMode <= ssp_ctrl_mode_type'(cm);
          for (int c = 0; c < 5; c++) stopCase(c);
        end
      end
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 0 : 1 + (($random(seed) & 32'h7FFFFFFF) % 100);
      doRestart(0, 0, m);
      for (int j = 1; j >= 0; j--) begin
        target <= 16'(maxSp * 100 + 150 * j);
        k = 0;
        @(negedge clock);
        while (speedFeedback !== target && k < 300) begin
          @(negedge clock);
          k++;
        end
        chk("speed settle", target, speedFeedback);
        if (speedFeedback !== target)
          close_out();
        repeat (2) @(negedge clock);
        chk("overspeed", j, 16'(overspeedAlarm));
      end
      chk("resolution bound", 16 * (101 - maxSp), encoderResolutionMax);
    end
    target <= 16'sh01F4;
    doRestart(2, 0, 50);
    h = 20 + ($random(seed) & 15);
    powerCutHoldTime <= 10'(h);
    // two short dips must not add up
    repeat (2) begin
      @(posedge clock);
      cut <= 1'b1;
      repeat ((h - 2) * 4) @(posedge clock);
      cut <= 1'b0;
      repeat (2) @(posedge clock);
    end
    @(negedge clock);
    chk("short dip cut", 0, 16'(powerCut));
    chk("short dip run", 1, 16'(stopState));
    @(posedge clock);
    cut <= 1'b1;
    k = 0;
    while (powerCut !== 1'b1 && k < 500) begin
      @(negedge clock);
      k++;
    end
    chk("cut delay", 1, 16'(k > h * 4 && k <= h * 4 + 12));
    if (powerCut !== 1'b1)
      close_out();
    @(negedge clock);
    chk("cut ready", 0, 16'(servoReady));
    chk("cut brake", 1, 16'(dynamicBrake));
    chk("cut power", 0, 16'(motorPower));
    @(posedge clock);
    cut <= 1'b0;
    waitFor(1, 10);
    chk("cut cleared", 0, 16'(powerCut));
    close_out();
  end
endmodule : ssp_stop_control_tb
`default_nettype wire
